// ==== rtl/acp_pkg.sv ====
// Constants and types shared by the cell port and its receive FIFO
package acp_pkg;
  localparam int BYTE_W = 8;
  localparam int PHY_ADDR_W = 2;
  localparam int LEN_W = 7;
  localparam logic [6:0] CELL_STD_LEN = 7'h35;
  localparam logic [6:0] CELL_MAX_LEN = 7'h40;
  localparam int CONN_COUNT = 32;
  localparam int CONN_IDX_W = 5;
  localparam logic [6:0] CONN_BYTE_IDX = 7'h03;
  localparam int CONN_LSB = 3;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W = 9;
  localparam int PACE_W = 16;
  localparam logic [3:0] PACE_CREDIT_MAX = 4'hF;
  localparam logic [2:0] SER_LAST_BIT = 3'h7;
  localparam logic [2:0] SER_FIRST_CNT = 3'h1;

  typedef enum logic [0:0] {
    ACP_IDLE = 1'b0,
    ACP_RUN = 1'b1
  } acp_state_type;
endpackage

// ==== rtl/acp_fifo_if.sv ====
// Valid/ready carrier between the cell port and its receive FIFO
interface acp_fifo_if #(parameter int W = 9);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic nearly_full;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;

  modport store (
    input in_valid, in_data, out_ready,
    output in_ready, nearly_full, out_valid, out_data
  );
  modport user (
    output in_valid, in_data, out_ready,
    input in_ready, nearly_full, out_valid, out_data
  );
endinterface

// ==== rtl/acp_fifo.sv ====
// Receive FIFO with registered read data
module acp_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Both sides
  acp_fifo_if.store q
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW:0] NEAR_CNT = (AW + 1)'(DEPTH - 1);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic ov_q;
  logic [W-1:0] od_q;

  wire push = q.in_valid && q.in_ready;
  wire load = (cnt_q != '0) && (!ov_q || q.out_ready);
  wire [AW:0] cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};

  assign q.in_ready = cnt_q != FULL_CNT;
  assign q.nearly_full = cnt_q >= NEAR_CNT;
  assign q.out_valid = ov_q;
  assign q.out_data = od_q;

  // Storage has no reset; only written entries are ever read
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_q] <= q.in_data;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ov_q <= 1'b0;
      od_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      if (push) begin
        wr_q <= (wr_q == LAST_PTR) ? '0 : wr_q + 1'b1;
      end
      if (load) begin
        rd_q <= (rd_q == LAST_PTR) ? '0 : rd_q + 1'b1;
        od_q <= mem[rd_q];
        ov_q <= 1'b1;
      end else if (q.out_ready) begin
        ov_q <= 1'b0;
      end
    end
  end
endmodule

// ==== rtl/acp_cell_port.sv ====
// Byte-wide cell port with pace scheduler, serial byte aligner and receive FIFO

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Cell data moves eight bits per cycle
// - Handshake checked once per whole cell
// - Cell waits in the PHY, then moves whole
// - Two-bit PHY address selects one of four
// - Receive wins over transmit at every start
// - Serial cells only on byte-aligned streams
// - Timer tick paces transmit cells
// - Lookup covers 32 internal connections
// - Cells of 53 up to 64 bytes
// - Ethernet channel off while cell port used
// - Cell port takes over port D pins
module acp_cell_port (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Configuration
  input wire logic cell_port_en,
  input wire logic [acp_pkg::LEN_W-1:0] cfg_cell_len,
  input wire logic [acp_pkg::PHY_ADDR_W-1:0] cfg_phy_addr,
  input wire logic [acp_pkg::PACE_W-1:0] cfg_pace_period,
  input wire logic [acp_pkg::CONN_COUNT-1:0] conn_en,
  // Cell port, shared pins
  output logic [acp_pkg::PHY_ADDR_W-1:0] phy_addr_q,
  output logic eth_disable_q,
  output logic port_d_sel_q,
  // Cell port, receive
  input wire logic [acp_pkg::BYTE_W-1:0] rx_cell_data,
  input wire logic rx_cell_avail,
  output logic rx_cell_enb_n_q,
  // Cell port, transmit
  output logic [acp_pkg::BYTE_W-1:0] tx_cell_data_q,
  output logic tx_cell_soc_q,
  output logic tx_cell_enb_n_q,
  input wire logic tx_cell_avail,
  // User side, received bytes
  output logic rx_out_valid,
  output logic rx_out_soc,
  output logic [acp_pkg::BYTE_W-1:0] rx_out_data,
  input wire logic rx_out_ready,
  output logic rx_conn_miss_q,
  // User side, bytes to send
  input wire logic tx_in_valid,
  input wire logic [acp_pkg::BYTE_W-1:0] tx_in_data,
  output logic tx_in_ready_q,
  // Serial channel
  input wire logic ser_bit_en,
  input wire logic ser_bit,
  input wire logic ser_byte_sync,
  output logic [acp_pkg::BYTE_W-1:0] ser_byte_q,
  output logic ser_byte_valid_q
);
  acp_fifo_if #(.W(acp_pkg::FIFO_W)) rxq ();

  acp_fifo #(
    .W(acp_pkg::FIFO_W),
    .DEPTH(acp_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .core_clk(core_clk),
    .resetn(resetn),
    .q(rxq.store)
  );

  acp_pkg::acp_state_type rx_st_q;
  acp_pkg::acp_state_type rx_st_d;
  acp_pkg::acp_state_type tx_st_q;
  acp_pkg::acp_state_type tx_st_d;
  logic [acp_pkg::LEN_W-1:0] len_q;
  logic [acp_pkg::LEN_W-1:0] rx_cnt_q;
  logic [acp_pkg::LEN_W-1:0] tx_cnt_q;
  logic rx_hit_q;
  logic [acp_pkg::PACE_W-1:0] pace_cnt_q;
  logic [3:0] credit_q;
  logic ser_aligned_q;
  logic [2:0] ser_cnt_q;
  logic [acp_pkg::BYTE_W-2:0] ser_shift_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Selection and arbitration

  // Out-of-range settings clamp so both directions always see a legal length
  wire [acp_pkg::LEN_W-1:0] len_sel =
    (cfg_cell_len < acp_pkg::CELL_STD_LEN) ? acp_pkg::CELL_STD_LEN :
    (cfg_cell_len > acp_pkg::CELL_MAX_LEN) ? acp_pkg::CELL_MAX_LEN :
    cfg_cell_len;
  wire [acp_pkg::LEN_W-1:0] len_last = len_q - 1'b1;
  wire busy = (rx_st_q == acp_pkg::ACP_RUN) || (tx_st_q == acp_pkg::ACP_RUN);
  // One PHY address is shared, so only one cell is in flight at a time
  wire rx_start = cell_port_en && !busy && rx_cell_avail && !rxq.nearly_full;
  wire tx_start = cell_port_en && !busy && !rx_cell_avail && tx_cell_avail
                  && (credit_q != '0) && tx_in_valid;
  wire rx_take = !rx_cell_enb_n_q;
  wire rx_last = rx_take && (rx_cnt_q == len_last);
  wire rx_more = (rx_st_q == acp_pkg::ACP_RUN) && !rx_last && !rxq.nearly_full;
  wire tx_take = tx_in_ready_q && tx_in_valid;
  wire tx_last = tx_take && (tx_cnt_q == len_last);
  wire pace_tick = pace_cnt_q >= cfg_pace_period;
  wire credit_inc = pace_tick && (credit_q != acp_pkg::PACE_CREDIT_MAX);
  wire [3:0] credit_d = credit_q + {3'h0, credit_inc} - {3'h0, tx_start};
  wire conn_byte = rx_take && (rx_cnt_q == acp_pkg::CONN_BYTE_IDX);
  wire [acp_pkg::CONN_IDX_W-1:0] conn_idx =
    rx_cell_data[acp_pkg::CONN_LSB +: acp_pkg::CONN_IDX_W];
  wire ser_step = ser_bit_en && (ser_byte_sync || ser_aligned_q);
  wire ser_done = ser_step && !ser_byte_sync && (ser_cnt_q == acp_pkg::SER_LAST_BIT);

  assign rxq.in_valid = rx_take;
  assign rxq.in_data = {rx_cnt_q == '0, rx_cell_data};
  assign rxq.out_ready = rx_out_ready;
  assign rx_out_valid = rxq.out_valid;
  assign rx_out_soc = rxq.out_data[acp_pkg::BYTE_W];
  assign rx_out_data = rxq.out_data[acp_pkg::BYTE_W-1:0];

  always_comb begin
    case (rx_st_q)
      acp_pkg::ACP_IDLE: rx_st_d = rx_start ? acp_pkg::ACP_RUN : acp_pkg::ACP_IDLE;
      acp_pkg::ACP_RUN: rx_st_d = rx_last ? acp_pkg::ACP_IDLE : acp_pkg::ACP_RUN;
      default: rx_st_d = acp_pkg::ACP_IDLE;
    endcase
  end

  always_comb begin
    case (tx_st_q)
      acp_pkg::ACP_IDLE: tx_st_d = tx_start ? acp_pkg::ACP_RUN : acp_pkg::ACP_IDLE;
      acp_pkg::ACP_RUN: tx_st_d = tx_last ? acp_pkg::ACP_IDLE : acp_pkg::ACP_RUN;
      default: tx_st_d = acp_pkg::ACP_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Port ownership and cell length

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      eth_disable_q <= 1'b0;
      port_d_sel_q <= 1'b0;
      phy_addr_q <= '0;
      len_q <= acp_pkg::CELL_STD_LEN;
    end else begin
      eth_disable_q <= cell_port_en;
      port_d_sel_q <= cell_port_en;
      if (rx_start || tx_start) begin
        // Address is only valid while a cell moves; outside glue gates by it
        phy_addr_q <= cfg_phy_addr;
        len_q <= len_sel;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rx_st_q <= acp_pkg::ACP_IDLE;
      rx_cnt_q <= '0;
      rx_cell_enb_n_q <= 1'b1;
      rx_hit_q <= 1'b0;
      rx_conn_miss_q <= 1'b0;
    end else begin
      rx_st_q <= rx_st_d;
      // FIFO margin of one keeps the byte already requested from being lost
      rx_cell_enb_n_q <= !(rx_start || rx_more);
      if (rx_start) begin
        rx_cnt_q <= '0;
      end else if (rx_take) begin
        rx_cnt_q <= rx_cnt_q + 1'b1;
      end
      if (conn_byte) begin
        rx_hit_q <= conn_en[conn_idx];
      end
      rx_conn_miss_q <= rx_last && !rx_hit_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit and pacing

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tx_st_q <= acp_pkg::ACP_IDLE;
      tx_cnt_q <= '0;
      tx_in_ready_q <= 1'b0;
      tx_cell_enb_n_q <= 1'b1;
      tx_cell_soc_q <= 1'b0;
      tx_cell_data_q <= '0;
      pace_cnt_q <= '0;
      credit_q <= '0;
    end else begin
      tx_st_q <= tx_st_d;
      tx_in_ready_q <= tx_start || (tx_in_ready_q && !tx_last);
      tx_cell_enb_n_q <= !tx_take;
      tx_cell_soc_q <= tx_take && (tx_cnt_q == '0);
      if (tx_take) begin
        tx_cell_data_q <= tx_in_data;
      end
      if (tx_start) begin
        tx_cnt_q <= '0;
      end else if (tx_take) begin
        tx_cnt_q <= tx_cnt_q + 1'b1;
      end
      pace_cnt_q <= pace_tick ? '0 : pace_cnt_q + 1'b1;
      credit_q <= credit_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Serial byte aligner

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ser_aligned_q <= 1'b0;
      ser_cnt_q <= '0;
      ser_shift_q <= '0;
      ser_byte_q <= '0;
      ser_byte_valid_q <= 1'b0;
    end else begin
      ser_byte_valid_q <= ser_done;
      if (ser_step) begin
        ser_shift_q <= {ser_shift_q[acp_pkg::BYTE_W-3:0], ser_bit};
      end
      // Without a sync there is no byte boundary, so bits are dropped
      if (ser_bit_en && ser_byte_sync) begin
        ser_aligned_q <= 1'b1;
        ser_cnt_q <= acp_pkg::SER_FIRST_CNT;
      end else if (ser_step) begin
        ser_cnt_q <= ser_cnt_q + 1'b1;
      end
      if (ser_done) begin
        ser_byte_q <= {ser_shift_q, ser_bit};
      end
    end
  end
endmodule

// ==== verification/acp_checker.sv ====
// Pin checker for the cell port
module acp_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Watched pins
  input wire logic cell_port_en,
  input wire logic [1:0] cfg_phy_addr,
  input wire logic [1:0] phy_addr_q,
  input wire logic eth_disable_q,
  input wire logic port_d_sel_q,
  input wire logic rx_cell_avail,
  input wire logic rx_cell_enb_n_q,
  input wire logic rx_conn_miss_q,
  input wire logic tx_cell_avail,
  input wire logic tx_cell_enb_n_q,
  input wire logic [7:0] tx_cell_data_q,
  input wire logic tx_in_valid,
  input wire logic [7:0] tx_in_data,
  input wire logic tx_in_ready_q,
  input wire logic ser_byte_valid_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Two edges of history so the reset value never counts
  a_eth_follow: assert property ($past(resetn, 2) |-> eth_disable_q == $past(cell_port_en))
    else $error("ethernet disable not following enable");
  a_portd_follow: assert property ($past(resetn, 2) |-> port_d_sel_q == $past(cell_port_en))
    else $error("port select not following enable");
  a_one_cell: assert property (!(!rx_cell_enb_n_q && !tx_cell_enb_n_q))
    else $error("receive and transmit cells overlap");
  a_rx_first: assert property ($rose(tx_in_ready_q) |-> !$past(rx_cell_avail))
    else $error("transmit began with a receive cell pending");
  a_tx_cause: assert property ($rose(tx_in_ready_q) |-> $past(tx_cell_avail && cell_port_en))
    else $error("transmit began without room at the far side");
  a_tx_byte: assert property (tx_in_valid && tx_in_ready_q
    |=> !tx_cell_enb_n_q && tx_cell_data_q == $past(tx_in_data))
    else $error("taken byte missing from the pins");
  a_phy_load: assert property ($rose(tx_in_ready_q) |-> phy_addr_q == $past(cfg_phy_addr))
    else $error("address not loaded at cell start");
  a_miss_end: assert property (rx_conn_miss_q |-> $rose(rx_cell_enb_n_q) ##1 !rx_conn_miss_q)
    else $error("miss pulse not at cell end");
  a_ser_pulse: assert property (ser_byte_valid_q |=> !ser_byte_valid_q)
    else $error("serial byte pulse too long");
  c_rx_cell: cover property ($fell(rx_cell_enb_n_q));
  c_tx_cell: cover property ($rose(tx_in_ready_q));
  c_miss: cover property (rx_conn_miss_q);
endmodule
bind acp_cell_port acp_checker u_acp_checker (.*);

// ==== verification/acp_phy_model.sv ====
// Far-side model holding one cell at a time
module acp_phy_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Bench control
  input wire logic rx_want,
  input wire logic [6:0] rx_len,
  input wire logic tx_room,
  // Cell port
  input wire logic rx_cell_enb_n_q,
  output logic [7:0] rx_cell_data,
  output logic rx_cell_avail,
  output logic tx_cell_avail
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] cnt_q;
  logic [7:0] last_q;
  // Cell waits here until the port asks, then goes out whole
  // Cells come only when the bench asks, so the average rate stays low
  assign rx_cell_avail = rx_want && cnt_q < rx_len;
  // One far device at any address, so the decode always selects it
  assign tx_cell_avail = tx_room;
  // Released line shows the inverse of the last byte
  assign rx_cell_data = rx_cell_enb_n_q ? ~last_q : 8'h10 + {1'b0, cnt_q};
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 7'h00;
      last_q <= 8'h00;
    end else if (!rx_want) begin
      cnt_q <= 7'h00;
    end else if (!rx_cell_enb_n_q) begin
      cnt_q <= cnt_q + 7'h01;
      last_q <= rx_cell_data;
    end
  end
endmodule

// ==== verification/acp_cell_port_tb.sv ====
// Self-checking bench for the cell port
module acp_cell_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, resetn, cell_port_en, rx_cell_avail, rx_cell_enb_n_q, tx_cell_soc_q;
  logic tx_cell_enb_n_q, tx_cell_avail, rx_out_valid, rx_out_soc, rx_out_ready, rx_conn_miss_q;
  logic tx_in_valid, tx_in_ready_q, ser_bit_en, ser_bit, ser_byte_sync, ser_byte_valid_q;
  logic eth_disable_q, port_d_sel_q, rx_want, tx_room;
  logic [6:0] cfg_cell_len, rx_len;
  logic [1:0] cfg_phy_addr, phy_addr_q;
  logic [15:0] cfg_pace_period;
  logic [31:0] conn_en;
  logic [7:0] rx_cell_data, tx_cell_data_q, rx_out_data, tx_in_data, ser_byte_q, ser_n;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  acp_cell_port u_acp_cell_port (.*);
  acp_phy_model u_acp_phy_model (.*);
  always #25 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Hold above zero stalls the user side so the FIFO fills and the port pauses
  task automatic t_rx(input logic [6:0] cfg, input logic [6:0] n, input logic miss, input int hold);
    int got;
    logic seen;
    got = 0;
    seen = 1'b0;
    @(posedge core_clk);
    cfg_cell_len <= cfg;
    rx_len <= n;
    conn_en <= miss ? 32'hFFFFFFFB : 32'hFFFFFFFF;
    rx_out_ready <= (hold == 0);
    rx_want <= 1'b1;
    for (int i = 0; i < 300; i++) begin
      @(posedge core_clk);
      if (i == hold) rx_out_ready <= 1'b1;
      @(negedge core_clk);
      if (i == hold - 1) chk(rx_cell_enb_n_q, 8'h01);
      if (rx_conn_miss_q === 1'b1) seen = 1'b1;
      if (rx_out_valid === 1'b1 && rx_out_ready === 1'b1) begin
        chk(rx_out_data, 8'h10 + got[7:0]);
        chk(rx_out_soc, got == 0);
        got++;
      end
    end
    chk(got[7:0], {1'b0, n});
    chk(seen, miss);
    @(posedge core_clk);
    rx_want <= 1'b0;
    $display("receive cell done");
  endtask
  // Transmit must wait for a pending receive cell and for pace credit
  task automatic t_tx(input logic [6:0] cfg, input logic [6:0] n, input logic with_rx,
                      input int wait_n);
    int nin;
    int nout;
    logic take;
    nin = 0;
    nout = 0;
    @(posedge core_clk);
    cfg_cell_len <= cfg;
    cfg_phy_addr <= 2'h2;
    rx_len <= 7'h35;
    rx_want <= with_rx;
    tx_room <= 1'b1;
    tx_in_valid <= 1'b1;
    tx_in_data <= 8'hA0;
    for (int i = 0; i < 300; i++) begin
      @(negedge core_clk);
      take = tx_in_ready_q === 1'b1 && tx_in_valid === 1'b1;
      if (i < wait_n) chk(tx_in_ready_q, 8'h00);
      if (take) chk(phy_addr_q, 8'h02);
      if (tx_cell_enb_n_q === 1'b0) begin
        chk(tx_cell_data_q, 8'hA0 + nout[7:0]);
        chk(tx_cell_soc_q, nout == 0);
        nout++;
      end
      @(posedge core_clk);
      if (take) begin
        nin++;
        tx_in_data <= 8'hA0 + nin[7:0];
        if (nin == n) tx_in_valid <= 1'b0;
      end
    end
    chk(nout[7:0], {1'b0, n});
    tx_room <= 1'b0;
    rx_want <= 1'b0;
    $display("transmit cell done");
  endtask
  task automatic t_ser(input logic [7:0] v, input int nb);
    for (int i = 0; i < nb; i++) begin
      @(posedge core_clk);
      ser_bit_en <= 1'b1;
      ser_bit <= v[7 - i];
      ser_byte_sync <= (i == 0);
    end
    @(posedge core_clk);
    ser_bit_en <= 1'b0;
    ser_byte_sync <= 1'b0;
  endtask
  // A cut byte, then a fresh sync restarts alignment
  task automatic t_serial();
    t_ser(8'hF0, 4);
    t_ser(8'h5A, 8);
    repeat (3) @(posedge core_clk);
    chk(ser_byte_q, 8'h5A);
    chk(ser_n, 8'h01);
    $display("serial test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    cyc++;
    if (!resetn) ser_n <= 8'h00;
    else if (ser_byte_valid_q === 1'b1) ser_n <= ser_n + 8'h01;
    if (cyc == 5000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    {core_clk, resetn, cell_port_en, rx_out_ready, tx_in_valid, rx_want, tx_room} = 7'h00;
    {ser_bit_en, ser_bit, ser_byte_sync, cfg_phy_addr, tx_in_data} = 13'h0000;
    cfg_cell_len = 7'h35;
    rx_len = 7'h35;
    cfg_pace_period = 16'h0063;
    conn_en = 32'hFFFFFFFF;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    @(negedge core_clk);
    chk(rx_cell_enb_n_q, 8'h01);
    chk(tx_cell_enb_n_q, 8'h01);
    @(posedge core_clk);
    cell_port_en <= 1'b1;
    repeat (2) @(negedge core_clk);
    chk(eth_disable_q, 8'h01);
    chk(port_d_sel_q, 8'h01);
    // No credit yet, so the first cell waits about a hundred cycles for a tick
    t_tx(7'h7F, 7'h40, 1'b0, 90);
    t_rx(7'h00, 7'h35, 1'b1, 0);
    t_rx(7'h40, 7'h40, 1'b0, 40);
    t_tx(7'h35, 7'h35, 1'b1, 50);
    t_serial();
    summarize();
  end
endmodule
